// ---- rtl/bls_consts.svh ----
// constants for the byte lane steering bus master
// assumes inclusion by bls_pkg and by the design modules
`ifndef BLS_CONSTS_SVH
`define BLS_CONSTS_SVH
`define BLS_LANES      8
`define BLS_LANE_BITS  8
`define BLS_DATA_BITS  64
`define BLS_ADDR_BITS  64
`define BLS_IDX_BITS   3
`define BLS_BEAT_BITS  3
`define BLS_BEAT_RST   3'h0
`define BLS_SEL_RST    8'h00
`define BLS_DATA_RST   64'h0000000000000000
`define BLS_ADDR_RST   64'h0000000000000000
`endif

// ---- rtl/bls_pkg.sv ----
// types shared by the byte lane steering bus master
// assumes bls_consts.svh is on the include path
`include "bls_consts.svh"
package bls_pkg;
  // unit size as log2 of bytes: port width, granularity, operand size
  typedef enum logic [1:0] {
    BLS_BYTE  = 2'h0,
    BLS_WORD  = 2'h1,
    BLS_DWORD = 2'h2,
    BLS_QWORD = 2'h3
  } bls_unit_type;
  typedef enum logic [0:0] {
    BLS_IDLE = 1'b0,
    BLS_XFER = 1'b1
  } bls_state_type;
endpackage

// ---- rtl/bls_lane_map.sv ----
// lane map: which port lanes carry which operand bytes in one beat
// assumes aligned operands and granularity not above port width
`timescale 1ns/1ps
`include "bls_consts.svh"
module bls_lane_map (
  // configuration
  input  wire bls_pkg::bls_unit_type i_port,
  input  wire bls_pkg::bls_unit_type i_gran,
  input  wire bls_pkg::bls_unit_type i_size,
  input  wire logic                  i_big,
  // position
  input  wire logic [2:0]            i_off,
  input  wire logic [2:0]            i_beat,
  // map
  output logic [7:0]                 o_valid,
  output logic [23:0]                o_idx,
  output logic [7:0]                 o_sel
);
  import bls_pkg::*;
  logic [3:0] base;
  logic [3:0] pbytes;
  logic [3:0] sbytes;
  assign base   = 4'({1'b0, i_beat} << i_port);
  assign pbytes = 4'(4'h1 << i_port);
  assign sbytes = 4'(4'h1 << i_size);
  genvar l;
  generate
    for (l = 0; l < `BLS_LANES; l++) begin : g_lane
      logic [3:0] o;
      logic [3:0] pos;
      logic [3:0] j;
      logic       in_port;
      assign in_port = 4'(l) < pbytes;
      // big endian: lowest address in the top lane of the port
      assign o   = i_big ? 4'(pbytes - 4'(l) - 4'h1) : 4'(l);
      assign pos = 4'(base + o);
      assign j   = 4'(pos - {1'b0, i_off});
      assign o_valid[l] = in_port && (pos >= {1'b0, i_off}) && (j < sbytes);
      // big endian: most significant byte at the lowest address
      assign o_idx[3*l +: 3] = i_big ? 3'(sbytes - j - 4'h1) : j[2:0];
    end
  endgenerate
  // one select line per granule of the active port
  always_comb begin
    o_sel = `BLS_SEL_RST;
    for (int k = 0; k < `BLS_LANES; k++) begin
      if (o_valid[k]) begin
        o_sel[3'(k >> i_gran)] = 1'b1;
      end
    end
  end
endmodule // bls_lane_map

// ---- rtl/bls_master.sv ----
// bus master that splits and steers 8..64 bit operands onto a shared bus port
// assumes slave on the same clock, classic handshake, ack only while strobe is high
//
// Behaviour
// - An operand wider than the port is carried over several bus cycles, two for 64 over 32 bits.
// - Pieces of a split operand go out in ascending address order, lowest address first.
// - A 64-bit byte-granular port addresses quadwords and maps bytes by endianness onto 8 lanes.
// - A 64-bit word-granular port has four 16-bit lanes with WORD(0) on top for big endian.
// - A 64-bit dword-granular port has two halves with DWORD(0) on top for big endian.
// - A 64-bit qword-granular port uses one select line for the whole bus.
// - A 32-bit byte-granular port has four byte lanes, BYTE(0) then BYTE(4) on top for big endian.
// - A 32-bit word-granular port has two 16-bit lanes, WORD(0) then WORD(2) on top for big endian.
// - A 32-bit dword-granular port carries DWORD(0) then DWORD(1) under one select line.
// - A 16-bit byte-granular port puts even bytes in the upper lane for big endian.
// - A 16-bit word-granular port passes words one per cycle under one select line.
// - An 8-bit port passes bytes one per cycle under one select line.
// - An operand smaller than the port granularity cannot be transferred.
// - Big endian keeps the most significant part at the lower address, little endian at the higher.
`timescale 1ns/1ps
`include "bls_consts.svh"
module bls_master (
  // clock and reset
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_NRST,
  // port configuration, taken with each request
  input  wire bls_pkg::bls_unit_type I_PORT,
  input  wire bls_pkg::bls_unit_type I_GRAN,
  input  wire logic                  I_BIG,
  // user request
  input  wire logic                  I_REQ,
  input  wire logic                  I_WRITE,
  input  wire bls_pkg::bls_unit_type I_SIZE,
  input  wire logic [63:0]           I_ADDR,
  input  wire logic [63:0]           I_WDATA,
  // user answer
  output logic                       O_BUSY,
  output logic                       O_DONE,
  output logic                       O_FAULT,
  output logic [63:0]                O_RDATA,
  // bus master side
  output logic                       O_CYC,
  output logic                       O_STB,
  output logic                       O_WE,
  output logic [63:0]                O_ADR,
  output logic [7:0]                 O_SEL,
  output logic [63:0]                O_DAT,
  input  wire logic                  I_ACK,
  input  wire logic [63:0]           I_DAT
);
  import bls_pkg::*;

  bls_state_type state;
  bls_unit_type  cfg_port;
  bls_unit_type  cfg_gran;
  bls_unit_type  cfg_size;
  logic          cfg_big;
  logic [63:0]   cfg_addr;
  logic [63:0]   wdata;
  logic [2:0]    beat;
  logic [2:0]    last_beat;
  logic [7:0]    cur_valid;
  logic [23:0]   cur_idx;
  logic [63:0]   acc;
  logic [63:0]   next_acc;

  logic          idle;
  logic          req_ok;
  logic          accept;
  logic          advance;
  logic          finish;
  bls_unit_type  m_port;
  bls_unit_type  m_gran;
  bls_unit_type  m_size;
  logic          m_big;
  logic [63:0]   m_addr;
  logic [63:0]   m_wdata;
  logic [2:0]    m_beat;
  logic [2:0]    m_off;
  logic [7:0]    m_valid;
  logic [23:0]   m_idx;
  logic [7:0]    m_sel;
  logic [63:0]   next_port_addr;
  logic [63:0]   next_dat;

  assign idle = (state == BLS_IDLE);
  // refuse operands below granularity, granules above the port, misaligned operands
  assign req_ok = (I_SIZE >= I_GRAN) && (I_GRAN <= I_PORT)
                && ((I_ADDR[2:0] & 3'((4'h1 << I_SIZE) - 4'h1)) == 3'h0);
  assign accept  = idle && I_REQ && req_ok;
  assign advance = !idle && O_STB && I_ACK && (beat != last_beat);
  assign finish  = !idle && O_STB && I_ACK && (beat == last_beat);

  // map source: fresh request when idle, otherwise the following beat
  assign m_port  = idle ? I_PORT : cfg_port;
  assign m_gran  = idle ? I_GRAN : cfg_gran;
  assign m_size  = idle ? I_SIZE : cfg_size;
  assign m_big   = idle ? I_BIG : cfg_big;
  assign m_addr  = idle ? I_ADDR : cfg_addr;
  assign m_wdata = idle ? I_WDATA : wdata;
  assign m_beat  = idle ? `BLS_BEAT_RST : 3'(beat + 3'h1);
  assign m_off   = m_addr[2:0] & 3'((4'h1 << m_port) - 4'h1);
  assign next_port_addr = {m_addr[63:3], m_addr[2:0] & ~m_off}
                        + 64'({m_beat, 3'h0} >> (3 - m_port));

  bls_lane_map i_bls_lane_map (
    .i_port  (m_port),
    .i_gran  (m_gran),
    .i_size  (m_size),
    .i_big   (m_big),
    .i_off   (m_off),
    .i_beat  (m_beat),
    .o_valid (m_valid),
    .o_idx   (m_idx),
    .o_sel   (m_sel)
  );

  // unselected lanes are driven as zero
  always_comb begin
    next_dat = `BLS_DATA_RST;
    for (int l = 0; l < `BLS_LANES; l++) begin
      if (m_valid[l]) begin
        next_dat[8*l +: 8] = m_wdata[8*m_idx[3*l +: 3] +: 8];
      end
    end
  end

  // read bytes gathered only from lanes selected in this beat
  always_comb begin
    next_acc = acc;
    for (int l = 0; l < `BLS_LANES; l++) begin
      if (cur_valid[l]) begin
        next_acc[8*cur_idx[3*l +: 3] +: 8] = I_DAT[8*l +: 8];
      end
    end
  end

  // sequencer
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= BLS_IDLE;
      beat  <= `BLS_BEAT_RST;
    end else if (accept) begin
      state <= BLS_XFER;
      beat  <= `BLS_BEAT_RST;
    end else if (advance) begin
      beat  <= 3'(beat + 3'h1);
    end else if (finish) begin
      state <= BLS_IDLE;
    end
  end

  // request capture
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg_port  <= BLS_BYTE;
      cfg_gran  <= BLS_BYTE;
      cfg_size  <= BLS_BYTE;
      cfg_big   <= 1'b0;
      cfg_addr  <= `BLS_ADDR_RST;
      wdata     <= `BLS_DATA_RST;
      last_beat <= `BLS_BEAT_RST;
    end else if (accept) begin
      cfg_port  <= I_PORT;
      cfg_gran  <= I_GRAN;
      cfg_size  <= I_SIZE;
      cfg_big   <= I_BIG;
      cfg_addr  <= I_ADDR;
      wdata     <= I_WDATA;
      // wider operand than port: one beat per port width
      last_beat <= (I_SIZE > I_PORT) ? 3'((4'h1 << (I_SIZE - I_PORT)) - 4'h1)
                                     : `BLS_BEAT_RST;
    end
  end

  // bus outputs, loaded per beat
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CYC     <= 1'b0;
      O_STB     <= 1'b0;
      O_WE      <= 1'b0;
      O_ADR     <= `BLS_ADDR_RST;
      O_SEL     <= `BLS_SEL_RST;
      O_DAT     <= `BLS_DATA_RST;
      cur_valid <= `BLS_SEL_RST;
      cur_idx   <= 24'h000000;
    end else if (accept || advance) begin
      O_CYC     <= 1'b1;
      O_STB     <= 1'b1;
      O_WE      <= idle ? I_WRITE : O_WE;
      O_ADR     <= next_port_addr >> m_gran;
      O_SEL     <= m_sel;
      O_DAT     <= (idle ? I_WRITE : O_WE) ? next_dat : `BLS_DATA_RST;
      cur_valid <= m_valid;
      cur_idx   <= m_idx;
    end else if (finish) begin
      O_CYC     <= 1'b0;
      O_STB     <= 1'b0;
      O_WE      <= 1'b0;
      O_SEL     <= `BLS_SEL_RST;
      O_DAT     <= `BLS_DATA_RST;
      cur_valid <= `BLS_SEL_RST;
    end
  end

  // user answer
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BUSY  <= 1'b0;
      O_DONE  <= 1'b0;
      O_FAULT <= 1'b0;
      O_RDATA <= `BLS_DATA_RST;
      acc     <= `BLS_DATA_RST;
    end else begin
      O_BUSY  <= accept || (O_BUSY && !finish);
      O_DONE  <= finish;
      O_FAULT <= idle && I_REQ && !req_ok;
      if (accept) begin
        acc <= `BLS_DATA_RST;
      end else if (!idle && O_STB && I_ACK) begin
        acc <= next_acc;
      end
      if (finish && !O_WE) begin
        O_RDATA <= next_acc;
      end
    end
  end

  // checks
  logic [3:0] ack_cnt;
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      ack_cnt <= 4'h0;
    end else if (accept) begin
      ack_cnt <= 4'h0;
    end else if (O_STB && I_ACK) begin
      ack_cnt <= 4'(ack_cnt + 4'h1);
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);

  a_beats_per_size: assert property (
    O_DONE |-> ack_cnt == ((cfg_size > cfg_port) ? 4'(4'h1 << (cfg_size - cfg_port)) : 4'h1))
    else $error("beat count does not match operand and port width");
  a_ascending_addr: assert property (
    advance |=> O_STB && (O_ADR > $past(O_ADR)))
    else $error("split operand not sent in ascending address order");
  a_byte64_lane: assert property (
    O_STB && cfg_port == BLS_QWORD && cfg_gran == BLS_BYTE && cfg_size == BLS_BYTE
    |-> O_SEL == (cfg_big ? (8'h80 >> cfg_addr[2:0]) : (8'h01 << cfg_addr[2:0]))
        && O_ADR == {cfg_addr[63:3], 3'h0})
    else $error("byte lane wrong on 64-bit byte port");
  a_word64_lane: assert property (
    O_STB && cfg_port == BLS_QWORD && cfg_gran == BLS_WORD && cfg_size == BLS_WORD
    |-> O_SEL == (cfg_big ? (8'h08 >> cfg_addr[2:1]) : (8'h01 << cfg_addr[2:1])))
    else $error("word lane wrong on 64-bit word port");
  a_dword64_half: assert property (
    O_STB && cfg_port == BLS_QWORD && cfg_gran == BLS_DWORD && cfg_size == BLS_DWORD
    |-> O_SEL == ((cfg_big ^ cfg_addr[2]) ? 8'h02 : 8'h01))
    else $error("dword half wrong on 64-bit dword port");
  a_qword64_all: assert property (
    O_STB && cfg_port == BLS_QWORD && cfg_gran == BLS_QWORD
    |-> O_SEL == 8'h01 && (!O_WE || O_DAT == wdata))
    else $error("qword port not carrying whole operand");
  a_byte32_lane: assert property (
    O_STB && cfg_port == BLS_DWORD && cfg_gran == BLS_BYTE && cfg_size == BLS_BYTE
    |-> O_SEL == (cfg_big ? (8'h08 >> cfg_addr[1:0]) : (8'h01 << cfg_addr[1:0])))
    else $error("byte lane wrong on 32-bit byte port");
  a_word32_addr: assert property (
    O_STB && cfg_port == BLS_DWORD && cfg_gran == BLS_WORD |-> O_ADR[0] == 1'b0)
    else $error("word address low bit set on 32-bit word port");
  a_dword32_order: assert property (
    accept && I_WRITE && I_PORT == BLS_DWORD && I_GRAN == BLS_DWORD && I_SIZE == BLS_QWORD
    |=> O_DAT[31:0] == (cfg_big ? wdata[63:32] : wdata[31:0]) && O_SEL == 8'h01)
    else $error("first dword of split qword wrong");
  a_byte16_lane: assert property (
    O_STB && cfg_port == BLS_WORD && cfg_gran == BLS_BYTE && cfg_size == BLS_BYTE
    |-> O_SEL == ((cfg_big ^ cfg_addr[0]) ? 8'h02 : 8'h01))
    else $error("byte lane wrong on 16-bit byte port");
  a_word16_single: assert property (
    O_STB && cfg_port == BLS_WORD && cfg_gran == BLS_WORD |-> O_SEL == 8'h01)
    else $error("16-bit word port select wrong");
  a_byte8_single: assert property (
    O_STB && cfg_port == BLS_BYTE |-> O_SEL == 8'h01 && O_DAT[63:8] == 56'h0)
    else $error("8-bit port drives beyond its lane");
  a_gran_refused: assert property (
    idle && I_REQ && I_SIZE < I_GRAN |=> O_FAULT && !O_CYC && !O_BUSY)
    else $error("operand below granularity not refused");
  a_wide_gran_refused: assert property (
    idle && I_REQ && I_GRAN > I_PORT |=> O_FAULT && !O_CYC && !O_BUSY)
    else $error("granule wider than port not refused");
  a_wait_hold: assert property (
    O_STB && !I_ACK |=> O_STB && $stable(O_ADR) && $stable(O_SEL) && $stable(O_DAT))
    else $error("bus beat changed before acknowledge");
  a_byte16_order: assert property (
    accept && I_WRITE && I_PORT == BLS_WORD && I_GRAN == BLS_BYTE && I_SIZE == BLS_QWORD
    |=> O_SEL == 8'h03 && O_DAT[15:0] == (cfg_big ? wdata[63:48] : wdata[15:0]))
    else $error("first bytes of split operand wrong on 16-bit port");

  c_split_read: cover property (finish && !O_WE && ack_cnt != 4'h0);
  c_split_write: cover property (advance && O_WE);
  c_fault: cover property (O_FAULT);
  c_big_single: cover property (O_DONE && cfg_big && cfg_size == cfg_port);
endmodule // bls_master

// ---- sim/bls_slave.sv ----
// partner model: byte memory slave on the steered bus port
// assumes the master's registered outputs and one shared clock
`timescale 1ns/1ps
module bls_slave (
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_nrst,
  // port configuration
  input  wire bls_pkg::bls_unit_type i_port,
  input  wire bls_pkg::bls_unit_type i_gran,
  input  wire logic                  i_big,
  // bus
  input  wire logic                  i_cyc,
  input  wire logic                  i_stb,
  input  wire logic                  i_we,
  input  wire logic [63:0]           i_adr,
  input  wire logic [7:0]            i_sel,
  input  wire logic [63:0]           i_dat,
  output logic                       o_ack,
  output logic [63:0]                o_dat
);
  import bls_pkg::*;
  logic [7:0] mem [0:63];
  logic [1:0] cnt;
  logic [1:0] wt;
  logic [7:0] noise;
  // memory byte behind bus byte b of this beat
  function automatic int place(input int b);
    int pb;
    pb = 1 << i_port;
    return ((int'(i_adr[7:0]) << i_gran) + (i_big ? pb - 1 - b : b)) & 63;
  endfunction
  function automatic logic lane_on(input int b);
    return b < (1 << i_port) && i_sel[b >> i_gran] === 1'b1;
  endfunction
  initial begin
    for (int k = 0; k < 64; k++) begin
      mem[k] = 8'(k * 37 + 5);
    end
  end
  // ack after 0..2 wait cycles
  assign o_ack = i_cyc && i_stb && (cnt >= wt);
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt   <= 2'h0;
      wt    <= 2'h0;
      noise <= 8'hA5;
    end else begin
      noise <= noise + 8'h3B;
      if (o_ack) begin
        cnt <= 2'h0;
        wt  <= 2'($urandom % 3);
        for (int b = 0; b < 8; b++) begin
          if (i_we && lane_on(b)) begin
            mem[place(b)] <= i_dat[b*8 +: 8];
          end
        end
      end else if (i_stb) begin
        cnt <= cnt + 2'h1;
      end
    end
  end
  // unselected lanes show a changing pattern
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      o_dat[b*8 +: 8] = lane_on(b) ? mem[place(b)] : noise ^ 8'(b);
    end
  end
endmodule // bls_slave

// ---- sim/test_bus_byte_lane_steering.sv ----
// testbench: directed and random steering traffic against a reference byte memory
// assumes bls_pkg, bls_master and bls_slave are compiled first
`timescale 1ns/1ps
module test_bus_byte_lane_steering;
  import bls_pkg::*;
  logic         I_CLOCK;
  logic         I_NRST;
  bls_unit_type I_PORT;
  bls_unit_type I_GRAN;
  bls_unit_type I_SIZE;
  logic         I_BIG;
  logic         I_REQ;
  logic         I_WRITE;
  logic [63:0]  I_ADDR;
  logic [63:0]  I_WDATA;
  logic         O_BUSY;
  logic         O_DONE;
  logic         O_FAULT;
  logic [63:0]  O_RDATA;
  logic         O_CYC;
  logic         O_STB;
  logic         O_WE;
  logic [63:0]  O_ADR;
  logic [7:0]   O_SEL;
  logic [63:0]  O_DAT;
  logic         I_ACK;
  logic [63:0]  I_DAT;
  int           bad_count;
  int           checks;
  int           beats;
  int           cur_p;
  int           cur_g;
  int           cur_s;
  int           cur_w;
  logic [63:0]  exp_adr;
  logic [63:0]  adr_q [$];
  logic [7:0]   ref_mem [0:63];
  bls_master i_bls_master (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_PORT(I_PORT),
    .I_GRAN(I_GRAN), .I_BIG(I_BIG), .I_REQ(I_REQ), .I_WRITE(I_WRITE), .I_SIZE(I_SIZE),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
    .O_FAULT(O_FAULT), .O_RDATA(O_RDATA), .O_CYC(O_CYC), .O_STB(O_STB), .O_WE(O_WE),
    .O_ADR(O_ADR), .O_SEL(O_SEL), .O_DAT(O_DAT), .I_ACK(I_ACK), .I_DAT(I_DAT));
  bls_slave i_bls_slave (.i_clock(I_CLOCK), .i_nrst(I_NRST), .i_port(I_PORT),
    .i_gran(I_GRAN), .i_big(I_BIG), .i_cyc(O_CYC), .i_stb(O_STB), .i_we(O_WE),
    .i_adr(O_ADR), .i_sel(O_SEL), .i_dat(O_DAT), .o_ack(I_ACK), .o_dat(I_DAT));
  initial begin
    I_CLOCK = 1'b0;
    forever #12.5 I_CLOCK = ~I_CLOCK;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // beat monitor: select count, direction and beat addresses from the queued model
  always @(posedge I_CLOCK) begin
    if (O_CYC === 1'b1 && O_STB === 1'b1 && I_ACK === 1'b1) begin
      chk(64'($countones(O_SEL)), 64'(1 << ((cur_s < cur_p ? cur_s : cur_p) - cur_g)));
      chk(64'({O_BUSY, O_WE}), 64'({1'b1, 1'(cur_w)}));
      if (adr_q.size() > 0) begin
        exp_adr = adr_q.pop_front();
      end else begin
        exp_adr = 64'hFFFFFFFFFFFFFFFF;
      end
      chk(O_ADR, exp_adr);
      beats = beats + 1;
    end
  end
  task automatic op(input int w, input int p, input int g, input int s, input int big,
                    input int a, input logic [63:0] v);
    int          n;
    int          nb;
    int          sh;
    logic        flt;
    logic [63:0] ex;
    flt = s < g || g > p || (a % (1 << s)) != 0;
    nb = flt ? 0 : (s > p ? 1 << (s - p) : 1);
    ex = 64'h0;
    @(posedge I_CLOCK);
    cur_p = p;
    cur_g = g;
    cur_s = s;
    cur_w = w;
    beats = 0;
    adr_q.delete();
    // one beat per port width, lowest address first, in granule units
    for (int i = 0; i < nb; i++) begin
      adr_q.push_back(64'(((a >> p) << (p - g)) + i * (1 << (p - g))));
    end
    I_REQ   <= 1'b1;
    I_WRITE <= 1'(w);
    I_PORT  <= bls_unit_type'(p);
    I_GRAN  <= bls_unit_type'(g);
    I_SIZE  <= bls_unit_type'(s);
    I_BIG   <= 1'(big);
    I_ADDR  <= 64'(a);
    I_WDATA <= v;
    @(posedge I_CLOCK);
    I_REQ <= 1'b0;
    for (n = 0; n < 60; n++) begin
      #1;
      if (O_DONE === 1'b1 || O_FAULT === 1'b1) break;
      @(posedge I_CLOCK);
    end
    chk(64'(n < 60), 64'h1);
    chk(64'(adr_q.size()), 64'h0);
    chk(64'({O_CYC, O_BUSY}), 64'h0);
    chk(64'(O_FAULT), 64'(flt));
    chk(64'(beats), 64'(nb));
    for (int k = 0; k < (1 << s) && !flt; k++) begin
      sh = 8 * (big != 0 ? (1 << s) - 1 - k : k);
      if (w != 0) begin
        ref_mem[a + k] = v[sh +: 8];
      end
      ex[sh +: 8] = ref_mem[a + k];
      chk(64'(i_bls_slave.mem[a + k]), 64'(ref_mem[a + k]));
    end
    if (w == 0 && !flt) begin
      chk(O_RDATA, ex);
    end
  endtask
  initial begin
    int s;
    int a;
    I_NRST = 1'b0;
    I_REQ = 1'b0;
    I_WRITE = 1'b0;
    I_PORT = BLS_BYTE;
    I_GRAN = BLS_BYTE;
    I_SIZE = BLS_BYTE;
    I_BIG = 1'b0;
    I_ADDR = 64'h0;
    I_WDATA = 64'h0;
    bad_count = 0;
    checks = 0;
    beats = 0;
    void'($urandom(87531));
    for (int k = 0; k < 64; k++) begin
      ref_mem[k] = 8'(k * 37 + 5);
    end
    repeat (8) @(posedge I_CLOCK);
    I_NRST <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 2; b++) begin
        op(1, p, 0, 3, b, 8, 64'h0123456789ABCDEF);
        op(0, p, p, p, b, 8, 64'h0);
        op(0, p, 0, 0, b, 9, 64'h0);
      end
    end
    $display("directed ordering test done");
    repeat (300) begin
      s = $urandom % 4;
      a = $urandom % 64;
      if ($urandom % 4 != 0) begin
        a = a & ~((1 << s) - 1);
      end
      op($urandom % 2, $urandom % 4, $urandom % 4, s, $urandom % 2, a,
         {$urandom, $urandom});
    end
    $display("random traffic test done");
    complete_run;
  end
  initial begin
    #(25 * 20000);
    bad_count++;
    complete_run;
  end
endmodule // test_bus_byte_lane_steering
